//--- rtl/lin_irq_pkg.sv
/*
 * Constants for the LIN interrupt-enable and dominant-timeout block:
 * register indices, the address width, field positions and reset values.
 * Assumes an APB slave with 32-bit words, one register per word.
 */
`default_nettype none
package lin_irq_pkg;
	// ==================================================================
	// register indices (byte address is four times the index)
	localparam int IDX_FLAGS = 32'h0000A095;
	localparam int IDX_IEN = 32'h0000A096;
	localparam int IDX_TCON = 32'h0000A0B0;
	localparam int IDX_TX_LO = 32'h0000A0B1;
	localparam int IDX_TX_HI = 32'h0000A0B2;
	localparam int IDX_RX_LO = 32'h0000A0B3;
	localparam int IDX_RX_HI = 32'h0000A0B4;
	localparam int ADDR_W = 18;
	// ==================================================================
	// interrupt-enable register fields
	localparam int IEN_GLOBAL = 7;
	localparam int IEN_BIT_MISMATCH_FLAG = 6;
	localparam int IEN_SYNC_MODE_SELECT = 5;
	localparam int IEN_SYNC_VALID_STATUS = 4;
	localparam int IEN_OPL = 4;
	// ==================================================================
	// timeout configuration fields
	localparam int TCON_RX0 = 7;
	localparam int TCON_EXIT = 6;
	localparam int TCON_RXWK = 5;
	localparam int TCON_TXWK = 4;
	localparam int TCON_RXF = 3;
	localparam int TCON_TXF = 2;
	localparam int TCON_RXDEN = 1;
	localparam int TCON_TXDEN = 0;
	// ==================================================================
	// flag register fields
	localparam int FLG_BIT_MISMATCH_FLAG = 6;
	localparam int FLG_EVT_W = 4;
	// ==================================================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic TXD_RECESSIVE = 1'b1;
endpackage
`default_nettype wire

//--- rtl/dom_timer_if.sv
/*
 * Carrier between the top module and one dominant-level timer.
 * Assumes the tick is a one-cycle pulse per oscillator period.
 */
`default_nettype none
interface dom_timer_if;
	logic dominant;
	logic tick;
	logic [16:0] limit;
	logic fault;
	modport timer(input dominant, input tick, input limit, output fault);
	modport ctrl(output dominant, output tick, output limit, input fault);
endinterface
`default_nettype wire

//--- rtl/event_flags.sv
/*
 * Sticky flags: set by hardware pulses, cleared by a software strobe.
 * Assumes set and clear are synchronous one-cycle strobes on pclk.
 */
`default_nettype none
module event_flags #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// set and clear strobes
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// state
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] f;
	} flag_state_t;
	flag_state_t state_reg;
	flag_state_t state_next;

	// ==================================================================
	// a set in the clearing cycle wins so no event is lost
	always_comb begin
		state_next = state_reg;
		state_next.f = (state_reg.f & ~clr) | set; // see [RL11] [RL12]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign flags = state_reg.f;

	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(|set) |=> ((flags & $past(set)) == $past(set))) // see [RL11]
		else $error("set flag not seen");
	a_no_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
		((|flags) && !(|clr)) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag cleared without software"); // see [RL12]
endmodule
`default_nettype wire

//--- rtl/dominant_timer.sv
/*
 * Counts oscillator ticks while a line is dominant and pulses a fault
 * once the count reaches the programmed limit plus one.
 * Assumes tick is a synchronous one-cycle pulse.
 */
`default_nettype none
module dominant_timer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// line and limit
	dom_timer_if.timer t
);
	typedef struct packed {
		logic [17:0] cnt;
		logic fault;
	} dt_state_t;
	dt_state_t state_reg;
	dt_state_t state_next;
	logic [17:0] target;

	// ==================================================================
	// counter saturates after firing, so one fault per dominant stretch
	always_comb begin
		state_next = state_reg;
		state_next.fault = 1'b0;
		target = 18'({1'b0, t.limit}) + 18'h00001; // see [RL14]
		if (!t.dominant) begin
			state_next.cnt = '0; // see [RL16]
		end else if (t.tick && state_reg.cnt < target) begin
			state_next.cnt = state_reg.cnt + 18'h00001;
			state_next.fault = (state_next.cnt == target); // see [RL16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign t.fault = state_reg.fault;

	a_fault_count: assert property (@(posedge pclk) disable iff (!presetn)
		t.fault |-> (state_reg.cnt == 18'({1'b0, t.limit}) + 18'h00001))
		else $error("fault at wrong count"); // see [RL14]
	a_fault_dominant: assert property (@(posedge pclk) disable iff (!presetn)
		t.fault |-> $past(t.dominant)) // see [RL16]
		else $error("fault without dominant line");
	c_fault_seen: cover property (@(posedge pclk) t.fault);
endmodule
`default_nettype wire

//--- rtl/lin_irq_timeout.sv
/*
 * LIN interrupt enables, sync mode, transmit polarity and dominant
 * fault timeouts, reached over APB.
 * Assumes the surrounding controller supplies event strobes and a
 * one-cycle tick per internal oscillator period, all on pclk.
 */
// Operation
// [RL1] global enable gates every LIN interrupt source
// [RL2] enable bit 6 gates the bit-error interrupt
// [RL3] sync mode loads each newly measured baud into the baud register
// [RL4] software sets sync mode whenever either auto-sync update is on
// [RL5] sync-valid status at bit 4 shows success while sync mode set
// [RL6] enable bit 4 written inverts transmit polarity, write only
// [RL7] bits 3..0 enable autosync, break sent, sync received, overflow
// [RL8] rx timeout is config bit 7, low byte 8..1, high byte 16..9
// [RL9] exit-on-fault set leaves break state on rx dominant fault
// [RL10] exit-on-fault clear never leaves break for rx fault
// [RL11] rx fault flag bit 3 set by hardware, cleared by software
// [RL12] tx fault flag bit 2 set by hardware, cleared by software
// [RL13] config bits 4 and 5 raise wake on tx or rx timeout
// [RL14] tx timeout is 16-bit value plus one oscillator periods
// [RL15] bit-error flag set on readback mismatch while enabled
// [RL16] fault after line dominant past timeout; recessive restarts
// [RL17] interrupt while global enable and an enabled flag set
`default_nettype none
module lin_irq_timeout
	import lin_irq_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [17:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// events from the lin controller
	input wire logic autosync_done,
	input wire logic break_sent,
	input wire logic sync_received,
	input wire logic sync_ok,
	input wire logic [15:0] measured_baud,
	input wire logic counter_overflow,
	input wire logic in_break_state,
	// bit readback
	input wire logic tx_bit,
	input wire logic bit_sample,
	// lines and oscillator tick
	input wire logic tx_data,
	input wire logic rxd,
	input wire logic internal_osc_clock,
	// outputs
	output logic txd_out,
	output logic baud_load,
	output logic [15:0] baud_value,
	output logic break_exit_req,
	output logic wake_req,
	output logic lin_irq
);
	// ==================================================================
	// state
	typedef struct packed {
		logic global_irq_enable;
		logic bit_error_irq_enable;
		logic sync_mode_select;
		logic sync_valid_status;
		logic tx_polarity_invert;
		logic [3:0] event_irq_enable;
		logic rx_to_bit0;
		logic break_exit_on_rx_fault;
		logic rx_timeout_wake_enable;
		logic tx_timeout_wake_enable;
		logic rx_dominant_fault_irq_enable;
		logic tx_dominant_fault_irq_enable;
		logic [7:0] tx_to_low;
		logic [7:0] tx_to_high;
		logic [7:0] rx_timeout_low_byte;
		logic [7:0] rx_timeout_high_byte;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic txd;
		logic load;
		logic [15:0] baud;
		logic brk_exit;
		logic wake;
		logic irq;
	} top_state_t;

	top_state_t state_reg;
	top_state_t state_next;

	logic [4:0] lin_flags;
	logic [4:0] lin_set;
	logic [4:0] lin_clr;
	logic [1:0] fault_flags;
	logic [1:0] fault_set;
	logic [1:0] fault_clr;
	logic [7:0] ien_rd;
	logic [7:0] tcon_rd;
	logic [7:0] flags_rd;
	logic wr_acc;
	logic setup;
	logic [7:0] wbyte;

	dom_timer_if tx_t();
	dom_timer_if rx_t();

	// ==================================================================
	// functions
	function automatic logic hit(input logic [17:0] a, input int idx);
		hit = (a == 18'(idx * 4));
	endfunction

	function automatic logic mapped(input logic [17:0] a);
		mapped = hit(a, IDX_FLAGS) | hit(a, IDX_IEN) | hit(a, IDX_TCON)
			| hit(a, IDX_TX_LO) | hit(a, IDX_TX_HI) | hit(a, IDX_RX_LO)
			| hit(a, IDX_RX_HI);
	endfunction

	// ==================================================================
	// dominant timers
	// tx watches the pin as driven, so polarity inversion is included
	assign tx_t.dominant = ~state_reg.txd; // see [RL16]
	assign tx_t.tick = internal_osc_clock;
	assign tx_t.limit = {1'b0, state_reg.tx_to_high,
		state_reg.tx_to_low}; // see [RL14]
	assign rx_t.dominant = ~rxd; // see [RL16]
	assign rx_t.tick = internal_osc_clock;
	assign rx_t.limit = {state_reg.rx_timeout_high_byte,
		state_reg.rx_timeout_low_byte, state_reg.rx_to_bit0}; // see [RL8]

	dominant_timer tx_timer (
		.pclk(pclk),
		.presetn(presetn),
		.t(tx_t)
	);

	dominant_timer rx_timer (
		.pclk(pclk),
		.presetn(presetn),
		.t(rx_t)
	);

	// ==================================================================
	// sticky flags
	assign wr_acc = psel & penable & state_reg.ready & pwrite;
	assign setup = psel & ~penable;
	assign wbyte = pwdata[7:0];

	// readback mismatch only counts while its interrupt is enabled
	assign lin_set = {
		bit_sample & state_reg.bit_error_irq_enable
			& (rxd != tx_bit), // see [RL15]
		autosync_done,
		break_sent,
		sync_received,
		counter_overflow
	};
	assign lin_clr = (wr_acc && hit(paddr, IDX_FLAGS))
		? {wbyte[FLG_BIT_MISMATCH_FLAG], wbyte[FLG_EVT_W-1:0]} : 5'h00;

	event_flags #(
		.W(5)
	) lin_flag_bits (
		.pclk(pclk),
		.presetn(presetn),
		.set(lin_set),
		.clr(lin_clr),
		.flags(lin_flags)
	);

	assign fault_set = {rx_t.fault, tx_t.fault}; // see [RL11] [RL12]
	assign fault_clr = (wr_acc && hit(paddr, IDX_TCON))
		? {wbyte[TCON_RXF], wbyte[TCON_TXF]} : 2'h0;

	event_flags #(
		.W(2)
	) fault_flag_bits (
		.pclk(pclk),
		.presetn(presetn),
		.set(fault_set),
		.clr(fault_clr),
		.flags(fault_flags)
	);

	// ==================================================================
	// read views
	// bit 4 reads the sync status; the polarity bit behind it is hidden
	assign ien_rd = {
		state_reg.global_irq_enable,
		state_reg.bit_error_irq_enable,
		state_reg.sync_mode_select,
		state_reg.sync_valid_status, // see [RL5] [RL6]
		state_reg.event_irq_enable
	};
	assign tcon_rd = {
		state_reg.rx_to_bit0,
		state_reg.break_exit_on_rx_fault,
		state_reg.rx_timeout_wake_enable,
		state_reg.tx_timeout_wake_enable,
		fault_flags,
		state_reg.rx_dominant_fault_irq_enable,
		state_reg.tx_dominant_fault_irq_enable
	};
	assign flags_rd = {1'b0, lin_flags[4], 2'b00, lin_flags[3:0]};

	// ==================================================================
	// next state
	always_comb begin
		state_next = state_reg;
		// apb: answer is prepared in setup, shown in the access cycle
		state_next.ready = setup;
		state_next.slverr = setup & ~mapped(paddr);
		state_next.rdata = 32'h00000000;
		if (setup && !pwrite) begin
			if (hit(paddr, IDX_FLAGS))
				state_next.rdata = {24'h000000, flags_rd};
			else if (hit(paddr, IDX_IEN))
				state_next.rdata = {24'h000000, ien_rd};
			else if (hit(paddr, IDX_TCON))
				state_next.rdata = {24'h000000, tcon_rd};
			else if (hit(paddr, IDX_TX_LO))
				state_next.rdata = {24'h000000, state_reg.tx_to_low};
			else if (hit(paddr, IDX_TX_HI))
				state_next.rdata = {24'h000000, state_reg.tx_to_high};
			else if (hit(paddr, IDX_RX_LO))
				state_next.rdata = {24'h000000,
					state_reg.rx_timeout_low_byte};
			else if (hit(paddr, IDX_RX_HI))
				state_next.rdata = {24'h000000,
					state_reg.rx_timeout_high_byte};
		end
		if (wr_acc && hit(paddr, IDX_IEN)) begin
			state_next.global_irq_enable = wbyte[IEN_GLOBAL];
			state_next.bit_error_irq_enable = wbyte[IEN_BIT_MISMATCH_FLAG];
			state_next.sync_mode_select = wbyte[IEN_SYNC_MODE_SELECT];
			state_next.tx_polarity_invert = wbyte[IEN_OPL]; // see [RL6]
			state_next.event_irq_enable = wbyte[3:0]; // see [RL7]
		end
		if (wr_acc && hit(paddr, IDX_TCON)) begin
			state_next.rx_to_bit0 = wbyte[TCON_RX0];
			state_next.break_exit_on_rx_fault = wbyte[TCON_EXIT];
			state_next.rx_timeout_wake_enable = wbyte[TCON_RXWK];
			state_next.tx_timeout_wake_enable = wbyte[TCON_TXWK];
			state_next.rx_dominant_fault_irq_enable = wbyte[TCON_RXDEN];
			state_next.tx_dominant_fault_irq_enable = wbyte[TCON_TXDEN];
		end
		if (wr_acc && hit(paddr, IDX_TX_LO))
			state_next.tx_to_low = wbyte;
		if (wr_acc && hit(paddr, IDX_TX_HI))
			state_next.tx_to_high = wbyte;
		if (wr_acc && hit(paddr, IDX_RX_LO))
			state_next.rx_timeout_low_byte = wbyte;
		if (wr_acc && hit(paddr, IDX_RX_HI))
			state_next.rx_timeout_high_byte = wbyte;

		// sync mode: each frame's measured baud is loaded on success;
		// setting the mode when auto-sync is wanted is software's job
		state_next.load = 1'b0;
		if (state_reg.sync_mode_select && sync_received) begin
			state_next.sync_valid_status = sync_ok; // see [RL5]
			if (sync_ok) begin
				state_next.load = 1'b1; // see [RL3]
				state_next.baud = measured_baud; // see [RL3]
			end
		end

		state_next.txd = tx_data ^ state_reg.tx_polarity_invert; // see [RL6]

		// without exit-on-fault the break state is left to software
		state_next.brk_exit = rx_t.fault & in_break_state
			& state_reg.break_exit_on_rx_fault; // see [RL9] [RL10]
		state_next.wake = (tx_t.fault & state_reg.tx_timeout_wake_enable)
			| (rx_t.fault & state_reg.rx_timeout_wake_enable); // see [RL13]

		state_next.irq = state_reg.global_irq_enable & ( // see [RL1] [RL17]
			(|(lin_flags[3:0] & state_reg.event_irq_enable)) // see [RL7]
			| (lin_flags[4] & state_reg.bit_error_irq_enable) // see [RL2]
			| (fault_flags[1] & state_reg.rx_dominant_fault_irq_enable)
			| (fault_flags[0] & state_reg.tx_dominant_fault_irq_enable));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.txd <= TXD_RECESSIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==================================================================
	// outputs
	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.slverr;
	assign txd_out = state_reg.txd;
	assign baud_load = state_reg.load;
	assign baud_value = state_reg.baud;
	assign break_exit_req = state_reg.brk_exit;
	assign wake_req = state_reg.wake;
	assign lin_irq = state_reg.irq;

	// ==================================================================
	// checks
	a_irq_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(state_reg.global_irq_enable) |-> !lin_irq) // see [RL1]
		else $error("interrupt without global enable");
	a_irq_from_flag: assert property (@(posedge pclk) disable iff (!presetn)
		($past(state_reg.global_irq_enable) && $past(fault_flags[1])
		&& $past(state_reg.rx_dominant_fault_irq_enable)) |-> lin_irq)
		else $error("enabled fault gave no interrupt"); // see [RL17]
	a_baud_load: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg.sync_mode_select && sync_received && sync_ok)
		|=> (baud_load && baud_value == $past(measured_baud))) // see [RL3]
		else $error("measured baud not loaded");
	a_no_load_off: assert property (@(posedge pclk) disable iff (!presetn)
		!state_reg.sync_mode_select |=> !baud_load) // see [RL3]
		else $error("baud loaded outside sync mode");
	a_polarity: assert property (@(posedge pclk) disable iff (!presetn)
		txd_out == ($past(tx_data) ^ $past(state_reg.tx_polarity_invert)))
		else $error("transmit polarity wrong"); // see [RL6]
	a_break_exit: assert property (@(posedge pclk) disable iff (!presetn)
		break_exit_req |-> $past(state_reg.break_exit_on_rx_fault)
		&& $past(rx_t.fault)) // see [RL10]
		else $error("break exit without enable");
	a_wake_tx: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_t.fault && state_reg.tx_timeout_wake_enable) |=> wake_req)
		else $error("tx timeout gave no wake"); // see [RL13]
	a_bit_error: assert property (@(posedge pclk) disable iff (!presetn)
		(bit_sample && state_reg.bit_error_irq_enable && rxd != tx_bit)
		|=> lin_flags[4]) // see [RL15]
		else $error("mismatch not flagged");
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("apb access not answered");
	c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(lin_irq));
	c_baud_loaded: cover property (@(posedge pclk) disable iff (!presetn)
		baud_load);
	c_break_exit: cover property (@(posedge pclk) disable iff (!presetn)
		break_exit_req);
	c_wake: cover property (@(posedge pclk) disable iff (!presetn)
		wake_req);
endmodule
`default_nettype wire

//--- test/lin_bus_model.sv
/*
 * Behavioural LIN bus with one remote node beside the block.
 * Assumes a pulled-up single-wire bus where any low driver wins.
 */
`default_nettype none
module lin_bus_model (
	// node transmit level
	input wire logic txd_out,
	// remote node pulls the bus dominant
	input wire logic remote_dominant,
	// bus level seen by the receiver
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// wired-and bus
	// pull-up makes the bus recessive once nobody drives it low
	assign rxd = txd_out & ~remote_dominant;
endmodule
`default_nettype wire

//--- test/tb_lin_irq_timeout.sv
/*
 * Self-checking bench for the LIN interrupt and dominant timeout block.
 * Assumes zero-wait APB answers and a bench-driven oscillator tick.
 */
`default_nettype none
module tb_lin_irq_timeout;
	import lin_irq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// signals
	logic pclk = 1'b0, presetn = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic pready, pslverr;
	logic [3:0] evt = 4'h0;
	logic sync_ok = 1'b0, in_break_state = 1'b0;
	logic [15:0] measured_baud = 16'h0000;
	logic tx_bit = 1'b1, bit_sample = 1'b0, tx_data = 1'b1;
	logic rxd, osc = 1'b0, remote_dom = 1'b0;
	logic txd_out, baud_load, break_exit_req, wake_req, lin_irq;
	logic [15:0] baud_value, baud_seen = 16'h0000;
	int n_mismatch = 0, check_count = 0;
	int n_wake = 0, n_exit = 0, n_load = 0;
	always #4 pclk = ~pclk;
	// ==================================================================
	// design and bus
	lin_irq_timeout dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.autosync_done(evt[3]), .break_sent(evt[2]),
		.sync_received(evt[1]), .sync_ok(sync_ok),
		.measured_baud(measured_baud), .counter_overflow(evt[0]),
		.in_break_state(in_break_state), .tx_bit(tx_bit),
		.bit_sample(bit_sample), .tx_data(tx_data), .rxd(rxd),
		.internal_osc_clock(osc), .txd_out(txd_out), .baud_load(baud_load),
		.baud_value(baud_value), .break_exit_req(break_exit_req),
		.wake_req(wake_req), .lin_irq(lin_irq));
	lin_bus_model bus (.txd_out(txd_out), .remote_dominant(remote_dom),
		.rxd(rxd));
	// pulses stand one cycle, so they are counted here
	always @(posedge pclk) begin
		if (wake_req === 1'b1) n_wake++;
		if (break_exit_req === 1'b1) n_exit++;
		if (baud_load === 1'b1) begin
			n_load++;
			baud_seen = baud_value;
		end
	end
	// ==================================================================
	// helpers
	task automatic report_and_stop();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask
	task automatic apb(input int idx, input logic is_wr, input logic [7:0] d,
			output logic [31:0] q, output logic err);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= 18'(idx * 4);
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: no pready", $time);
			report_and_stop();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input int idx, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(idx, 1'b1, d, q, e);
	endtask
	task automatic rd(input int idx, input logic [7:0] exp, input string m);
		logic [31:0] q;
		logic e;
		apb(idx, 1'b0, 8'h00, q, e);
		chk(q, {24'h000000, exp}, m);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			osc <= 1'b1;
			@(posedge pclk);
			osc <= 1'b0;
			@(posedge pclk);
		end
	endtask
	// hold one line dominant for exactly n oscillator ticks
	task automatic dom_run(input logic on_tx, input int n);
		if (on_tx) tx_data <= 1'b0;
		else remote_dom <= 1'b1;
		repeat (3) @(posedge pclk);
		ticks(n);
		repeat (4) @(posedge pclk);
		tx_data <= 1'b1;
		remote_dom <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	// ==================================================================
	// scenarios
	task automatic scen_regs();
		logic [31:0] q;
		logic e;
		rd(IDX_FLAGS, 8'h00, "flags reset");
		rd(IDX_IEN, 8'h00, "enables reset");
		rd(IDX_TCON, 8'h00, "config reset");
		rd(IDX_RX_LO, 8'h00, "rx low reset");
		wr(IDX_TX_LO, 8'hA5);
		rd(IDX_TX_LO, 8'hA5, "tx low rw");
		apb('hA0A0, 1'b0, 8'h00, q, e);
		chk({31'h0, e}, 32'h1, "unmapped err");
		chk(q, 32'h0, "unmapped data");
	endtask
	task automatic scen_events();
		for (int k = 0; k < FLG_EVT_W; k++) begin
			wr(IDX_IEN, 8'h80 | 8'(1 << k));
			evt[k] <= 1'b1;
			@(posedge pclk);
			evt[k] <= 1'b0;
			repeat (3) @(posedge pclk);
			chk({31'h0, lin_irq}, 32'h1, "irq on event");
			rd(IDX_FLAGS, 8'(1 << k), "event flag");
			wr(IDX_IEN, 8'(1 << k));
			// the interrupt register follows the enable one cycle late
			@(posedge pclk);
			chk({31'h0, lin_irq}, 32'h0, "global gate");
			wr(IDX_FLAGS, 8'(1 << k));
			rd(IDX_FLAGS, 8'h00, "flag cleared");
		end
	endtask
	task automatic scen_bit_error();
		tx_bit <= 1'b0;
		wr(IDX_IEN, 8'h80);
		bit_sample <= 1'b1;
		@(posedge pclk);
		bit_sample <= 1'b0;
		rd(IDX_FLAGS, 8'h00, "mismatch while disabled");
		wr(IDX_IEN, 8'hC0);
		bit_sample <= 1'b1;
		@(posedge pclk);
		bit_sample <= 1'b0;
		rd(IDX_FLAGS, 8'h40, "mismatch flagged");
		chk({31'h0, lin_irq}, 32'h1, "bit error irq");
		wr(IDX_FLAGS, 8'h40);
		tx_bit <= 1'b1;
		rd(IDX_FLAGS, 8'h00, "mismatch cleared");
	endtask
	task automatic scen_sync();
		sync_ok <= 1'b1;
		measured_baud <= 16'hA5C3;
		evt[1] <= 1'b1;
		@(posedge pclk);
		evt[1] <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(n_load, 0, "no load outside sync mode");
		wr(IDX_IEN, 8'h20);
		evt[1] <= 1'b1;
		@(posedge pclk);
		evt[1] <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(n_load, 1, "baud load");
		chk({16'h0, baud_seen}, 32'h0000A5C3, "baud value");
		rd(IDX_IEN, 8'h30, "sync valid set");
		sync_ok <= 1'b0;
		evt[1] <= 1'b1;
		@(posedge pclk);
		evt[1] <= 1'b0;
		rd(IDX_IEN, 8'h20, "sync valid clear");
		wr(IDX_FLAGS, 8'h02);
	endtask
	task automatic scen_polarity();
		// the pin register follows the polarity bit one cycle late
		wr(IDX_IEN, 8'h10);
		@(posedge pclk);
		chk({31'h0, txd_out}, 32'h0, "inverted tx");
		rd(IDX_IEN, 8'h00, "polarity not readable");
		wr(IDX_IEN, 8'h00);
		@(posedge pclk);
		chk({31'h0, txd_out}, 32'h1, "normal tx");
	endtask
	task automatic scen_tx_timeout();
		wr(IDX_TX_LO, 8'h00);
		wr(IDX_TX_HI, 8'h01);
		wr(IDX_RX_LO, 8'h01);
		wr(IDX_RX_HI, 8'h01);
		wr(IDX_TCON, 8'h91);
		wr(IDX_IEN, 8'h80);
		dom_run(1'b1, 256);
		dom_run(1'b1, 256);
		rd(IDX_TCON, 8'h91, "no tx fault at limit");
		dom_run(1'b1, 257);
		rd(IDX_TCON, 8'h95, "tx fault");
		chk({31'h0, lin_irq}, 32'h1, "tx fault irq");
		chk(n_wake, 1, "tx wake");
		wr(IDX_TCON, 8'h95);
		rd(IDX_TCON, 8'h91, "tx flag cleared");
		chk({31'h0, lin_irq}, 32'h0, "irq released");
	endtask
	task automatic scen_rx_timeout();
		in_break_state <= 1'b1;
		wr(IDX_TCON, 8'hE2);
		dom_run(1'b0, 515);
		rd(IDX_TCON, 8'hE2, "no rx fault at limit");
		dom_run(1'b0, 516);
		rd(IDX_TCON, 8'hEA, "rx fault");
		chk({31'h0, lin_irq}, 32'h1, "rx fault irq");
		chk(n_exit, 1, "break exit");
		chk(n_wake, 2, "rx wake");
		wr(IDX_TCON, 8'hEA);
		wr(IDX_TCON, 8'hA2);
		dom_run(1'b0, 516);
		rd(IDX_TCON, 8'hAA, "rx fault again");
		chk(n_exit, 1, "no exit when disabled");
		chk(n_wake, 3, "rx wake again");
		in_break_state <= 1'b0;
	endtask
	// ==================================================================
	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		scen_regs();
		scen_events();
		scen_bit_error();
		scen_sync();
		scen_polarity();
		scen_tx_timeout();
		scen_rx_timeout();
		report_and_stop();
	end
endmodule
`default_nettype wire
